// ===== rtl/mas_alarm_status.sv
`timescale 1ns/1ps
// Contract
// (RL1) Low and high threshold bytes live at 000Bh and 000Ch, host writable.
// (RL2) Samples strictly inside the band record no alarm.
// (RL3) Out-of-band sample sets high or low flag in status at 0014h.
// (RL4) Interrupt asserts for high alarm with its enable, low alarm likewise.
// (RL5) Excursion start copies three-byte sample count, low byte first.
// (RL6) Duration byte after stamp counts readings beyond the threshold.
// (RL7) After 255 readings and still out, new stamp and counter follow.
// (RL8) Return inside band freezes counter; later crossing opens new stamp.
// (RL9) Low excursions stored in 0220h to 024Fh.
// (RL10) High excursions stored in 0250h to 027Fh, twelve events per band.
// (RL11) Indication is four low pulses, 62.5 ms each, every half second.
// (RL12) Mission start pulses both outputs together four times.
// (RL13) Status request pulses good output if all in band, else bad output.
// (RL14) Request before first sample alternates four pulses, bad output first.
// (RL15) Status request via spec test command or button held half second.
// (RL16) Time, calendar, alarm in BCD; unused bits always read zero.
// (RL17) Hours bit 6 selects 12-hour; bit 5 is PM or twenty-hours digit.
// (RL18) Four alarm registers 0007h-000Ah, mask bit 7, match 0000h-0003h.
// (RL19) Alarm fires on every unmasked field matching; all masked each second.
// (RL20) Changing a time or control register stops the mission.
// (RL21) Temperature and alarm flags stay set until host writes zero.
// (RL22) Alarm flag set on match; drives interrupt only when enabled.
// (RL23) Full region discards further stamps, leaving stored entries intact.
// (RL24) New indication request restarts the four-pulse sequence.
module mas_alarm_status #(
   parameter int LED_PULSE_CYC  = mas_pkg::LED_PULSE_CYC,
   parameter int LED_PERIOD_CYC = mas_pkg::LED_PERIOD_CYC,
   parameter int BTN_HOLD_CYC   = mas_pkg::BTN_HOLD_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  tick_1s,
   input  wire mas_pkg::mas_reg_req_s reg_req,
   output logic [7:0]                 reg_rdata,
   input  wire mas_pkg::mas_sample_s  sample,
   input  wire logic                  mission_start,
   input  wire logic                  spec_test_cmd,
   input  wire logic                  pushbutton_n,
   output logic                       good_led_n,
   output logic                       bad_led_n,
   output logic                       int_n,
   output logic                       mission_active
);
   localparam int TW = mas_pkg::TIMER_W;
   localparam logic [TW-1:0] PULSE_L  = TW'(LED_PULSE_CYC);
   localparam logic [TW-1:0] PERIOD_L = TW'(LED_PERIOD_CYC - 1);
   localparam logic [TW-1:0] HOLD_L   = TW'(BTN_HOLD_CYC - 1);
   localparam logic [1:0]    LAST_P   = 2'(mas_pkg::LED_PULSES - 1);

   mas_pkg::mas_byte_t time_q [4], time_d [4];
   mas_pkg::mas_byte_t alm_q [4], alm_d [4];
   mas_pkg::mas_byte_t th_lo_q, th_lo_d, th_hi_q, th_hi_d, ctrl_q, ctrl_d;
   logic mip_q, mip_d, tlf_q, tlf_d, thf_q, thf_d, tod_alarm_flag_q, tod_alarm_flag_d;
   logic seen_q, seen_d, anyout_q, anyout_d;
   logic [7:0] rd_val, wmask, rdata_q;
   logic [1:0] band_out, samp_set;
   logic [1:0][7:0] ev_rd;
   logic [1:0] ev_hit;
   logic [15:0] a;
   logic samp_ok, wr;

   // Binary-coded decimal increment: {carry, next}, wraps max to lo
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] max,
                                          input logic [7:0] lo);
      logic [8:0] r;
      if (v == max) r = {1'b1, lo};
      else if (v[3:0] == 4'h9) r = {1'b0, v[7:4] + 4'h1, 4'h0};
      else r = {1'b0, v + 8'h01};
      return r;
   endfunction : bcd_inc

   assign a       = reg_req.addr;
   assign wr      = reg_req.wr;
   assign samp_ok = sample.valid & mip_q;
   // Strictly inside the band gives neither term
   assign band_out[0] = sample.temp <= th_lo_q;  // RL2
   assign band_out[1] = sample.temp >= th_hi_q;  // RL2
   assign samp_set    = band_out & {2{samp_ok}};

   // Read mux and writable mask per address
   always_comb begin
      rd_val = 8'h00;
      wmask  = 8'h00;
      if (a <= mas_pkg::A_DAY) begin
         rd_val = time_q[a[1:0]];
         unique case (a[1:0])
            2'd0: wmask = mas_pkg::M_SEC;
            2'd1: wmask = mas_pkg::M_MIN;
            2'd2: wmask = mas_pkg::M_HRS;
            2'd3: wmask = mas_pkg::M_DAY;
         endcase
      end else if (a >= mas_pkg::A_ALM_SEC && a <= mas_pkg::A_ALM_DAY) begin
         rd_val = alm_q[2'(a - mas_pkg::A_ALM_SEC)];
         wmask  = (a == mas_pkg::A_ALM_DAY) ? mas_pkg::M_ALM_DAY
                                            : mas_pkg::M_ALM;
      end else if (a == mas_pkg::A_TH_LO) begin
         rd_val = th_lo_q;
         wmask  = 8'hff;
      end else if (a == mas_pkg::A_TH_HI) begin
         rd_val = th_hi_q;
         wmask  = 8'hff;
      end else if (a == mas_pkg::A_CTRL) begin
         rd_val = ctrl_q;
         wmask  = mas_pkg::M_CTRL;
      end else if (a == mas_pkg::A_STATUS) begin
         rd_val = 8'h00;
         rd_val[mas_pkg::ST_MIP]  = mip_q;
         rd_val[mas_pkg::ST_TLF]  = tlf_q;
         rd_val[mas_pkg::ST_THF]  = thf_q;
         rd_val[mas_pkg::ST_TOD_ALARM_FLAG] = tod_alarm_flag_q;
      end else if (ev_hit[0]) begin
         rd_val = ev_rd[0];
      end else if (ev_hit[1]) begin
         rd_val = ev_rd[1];
      end
   end

   // Timekeeping, alarm, thresholds, control and status flags
   always_comb begin
      logic [8:0] r;
      logic       c, pm, day_c, match;
      r = 9'h000;
      c = 1'b0;
      day_c = 1'b0;
      match = 1'b1;
      time_d = time_q;
      alm_d = alm_q;
      th_lo_d = th_lo_q;
      th_hi_d = th_hi_q;
      ctrl_d = ctrl_q;
      mip_d = mip_q;
      tlf_d = tlf_q;
      thf_d = thf_q;
      tod_alarm_flag_d = tod_alarm_flag_q;
      seen_d = seen_q;
      anyout_d = anyout_q;
      pm = time_q[2][mas_pkg::HR_PM];
      if (tick_1s) begin
         r = bcd_inc(time_q[0], mas_pkg::BCD_59, mas_pkg::BCD_0);
         time_d[0] = r[7:0];
         c = r[8];
         if (c) begin
            r = bcd_inc(time_q[1], mas_pkg::BCD_59, mas_pkg::BCD_0);
            time_d[1] = r[7:0];
            c = r[8];
         end
         if (c && time_q[2][mas_pkg::HR_12]) begin  // RL17
            r = {1'b0, 3'b000, time_q[2][4:0]};
            if (r[7:0] == mas_pkg::BCD_11) begin
               day_c = pm;
               pm = ~pm;
               r[7:0] = mas_pkg::BCD_12;
            end else begin
               r = bcd_inc(r[7:0], mas_pkg::BCD_12, mas_pkg::BCD_1);
            end
            time_d[2] = {2'b01, pm, r[4:0]};
         end else if (c) begin
            r = bcd_inc({2'b00, time_q[2][5:0]}, mas_pkg::BCD_23,
                        mas_pkg::BCD_0);  // RL17
            time_d[2] = r[7:0];
            day_c = r[8];
         end
         if (day_c) begin
            r = bcd_inc(time_q[3], mas_pkg::BCD_7, mas_pkg::BCD_1);
            time_d[3] = r[7:0];
         end
         // Each unmasked field must match the advanced time
         for (int i = 0; i < 4; i++) begin
            if (!alm_q[i][mas_pkg::ALM_MASK] &&
                alm_q[i][6:0] != time_d[i][6:0]) begin
               match = 1'b0;  // RL19
            end
         end
      end else begin
         match = 1'b0;
      end
      // Host write; masked bits never stored so they read zero
      if (wr) begin
         if (a <= mas_pkg::A_DAY) begin
            time_d[a[1:0]] = reg_req.wdata & wmask;  // RL16
         end else if (a >= mas_pkg::A_ALM_SEC &&
                      a <= mas_pkg::A_ALM_DAY) begin
            alm_d[2'(a - mas_pkg::A_ALM_SEC)] = reg_req.wdata & wmask;  // RL18
         end else if (a == mas_pkg::A_TH_LO) begin
            th_lo_d = reg_req.wdata;  // RL1
         end else if (a == mas_pkg::A_TH_HI) begin
            th_hi_d = reg_req.wdata;  // RL1
         end else if (a == mas_pkg::A_CTRL) begin
            ctrl_d = reg_req.wdata & wmask;
         end else if (a == mas_pkg::A_STATUS) begin
            // Flags clear only by writing zero; mission bit by writing zero or by a tamper write
            mip_d  = mip_q & reg_req.wdata[mas_pkg::ST_MIP];
            tlf_d  = tlf_q & reg_req.wdata[mas_pkg::ST_TLF];  // RL21
            thf_d  = thf_q & reg_req.wdata[mas_pkg::ST_THF];  // RL21
            tod_alarm_flag_d = tod_alarm_flag_q & reg_req.wdata[mas_pkg::ST_TOD_ALARM_FLAG];  // RL21
         end
         // Tamper guard: only a real change stops the mission
         if (a <= mas_pkg::A_CTRL && wmask != 8'h00 &&
             (reg_req.wdata & wmask) != rd_val) begin
            mip_d = 1'b0;  // RL20
         end
      end
      // Hardware sets win over a clearing write in the same cycle
      if (match) tod_alarm_flag_d = 1'b1;  // RL22
      if (samp_set[0]) tlf_d = 1'b1;  // RL3
      if (samp_set[1]) thf_d = 1'b1;  // RL3
      if (samp_ok) seen_d = 1'b1;
      if (|samp_set) anyout_d = 1'b1;
      if (mission_start) begin
         mip_d = 1'b1;
         seen_d = 1'b0;
         anyout_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         time_q <= '{default: 8'h00};
         alm_q <= '{default: 8'h00};
         th_lo_q <= 8'h00;
         th_hi_q <= 8'h00;
         ctrl_q <= 8'h00;
         {mip_q, tlf_q, thf_q, tod_alarm_flag_q, seen_q, anyout_q} <= 6'h00;
         rdata_q <= 8'h00;
      end else begin
         time_q <= time_d;
         alm_q <= alm_d;
         th_lo_q <= th_lo_d;
         th_hi_q <= th_hi_d;
         ctrl_q <= ctrl_d;
         {mip_q, tlf_q, thf_q, tod_alarm_flag_q, seen_q, anyout_q} <=
            {mip_d, tlf_d, thf_d, tod_alarm_flag_d, seen_d, anyout_d};
         rdata_q <= rd_val;
      end
   end

   // Excursion logging, one region per band (0 low, 1 high)
   for (genvar b = 0; b < 2; b++) begin : g_band
      localparam logic [15:0] BASE = b ? mas_pkg::A_EV_HI : mas_pkg::A_EV_LO;
      mas_pkg::mas_byte_t ev_q [48], ev_d [48];
      logic       exc_q, exc_d, live_q, live_d;
      logic [3:0] ptr_q, ptr_d, last;
      logic [7:0] dur_q, dur_d;
      logic [15:0] off;

      assign off   = a - BASE;
      assign ev_hit[b] = a >= BASE && off < mas_pkg::EV_BYTES;  // RL9 RL10
      assign ev_rd[b]  = ev_hit[b] ? ev_q[off[5:0]] : 8'h00;
      assign last  = ptr_q - 4'h1;

      always_comb begin
         ev_d = ev_q;
         exc_d = exc_q;
         live_d = live_q;
         ptr_d = ptr_q;
         dur_d = dur_q;
         if (mission_start) begin
            exc_d = 1'b0;
            live_d = 1'b0;
            ptr_d = 4'h0;
            dur_d = 8'h00;
         end else if (samp_ok) begin
            if (!band_out[b]) begin
               exc_d = 1'b0;  // RL8
            end else if (!exc_q || dur_q == mas_pkg::DUR_MAX) begin  // RL7
               exc_d = 1'b1;
               dur_d = 8'h01;
               live_d = 1'b0;
               if (ptr_q < mas_pkg::EV_ENTRIES) begin  // RL23
                  ev_d[{ptr_q, 2'd0}] = sample.count[7:0];  // RL5
                  ev_d[{ptr_q, 2'd1}] = sample.count[15:8];
                  ev_d[{ptr_q, 2'd2}] = sample.count[23:16];
                  ev_d[{ptr_q, 2'd3}] = 8'h01;  // RL6
                  ptr_d = ptr_q + 4'h1;
                  live_d = 1'b1;
               end
            end else begin
               dur_d = dur_q + 8'h01;  // RL6
               if (live_q) ev_d[{last, 2'd3}] = dur_q + 8'h01;
            end
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            ev_q <= '{default: 8'h00};
            exc_q <= 1'b0;
            live_q <= 1'b0;
            ptr_q <= 4'h0;
            dur_q <= 8'h00;
         end else begin
            ev_q <= ev_d;
            exc_q <= exc_d;
            live_q <= live_d;
            ptr_q <= ptr_d;
            dur_q <= dur_d;
         end
      end
   end

   // Pushbutton and LED sequencer
   logic btn_s1_q, btn_s2_q, btn_s3_q, btn_lvl_q, btn_lvl_d, fire;
   logic [TW-1:0] hold_q, hold_d, cnt_q, cnt_d;
   logic run_q, run_d, good_q, good_d, bad_q, bad_d, int_q, int_d;
   logic [1:0] idx_q, idx_d;
   mas_pkg::mas_led_e pat_q, pat_d;

   always_comb begin
      logic on;
      btn_lvl_d = (btn_s2_q == btn_s3_q) ? btn_s3_q : btn_lvl_q;
      hold_d = btn_lvl_q ? '0 : (hold_q == HOLD_L ? hold_q : hold_q + 1'b1);
      // Fires once per press, only with a mission already running
      fire = !btn_lvl_q && hold_q == HOLD_L - 1'b1 && mip_q;  // RL15
      run_d = run_q;
      pat_d = pat_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      if (mission_start) begin
         run_d = 1'b1;  // RL24
         pat_d = mas_pkg::LED_BOTH;  // RL12
         cnt_d = '0;
         idx_d = 2'd0;
      end else if (spec_test_cmd || fire) begin  // RL15
         run_d = 1'b1;  // RL24
         cnt_d = '0;
         idx_d = 2'd0;
         if (mip_q && !seen_q) pat_d = mas_pkg::LED_ALT;  // RL14
         else if (anyout_q) pat_d = mas_pkg::LED_BAD;  // RL13
         else pat_d = mas_pkg::LED_GOOD;  // RL13
      end else if (run_q) begin
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == PERIOD_L) begin  // RL11
            cnt_d = '0;
            if (idx_q == LAST_P) run_d = 1'b0;
            else idx_d = idx_q + 2'd1;
         end
      end
      on = run_d && cnt_d < PULSE_L;  // RL11
      good_d = !(on && (pat_d == mas_pkg::LED_BOTH ||
                        pat_d == mas_pkg::LED_GOOD ||
                        (pat_d == mas_pkg::LED_ALT && idx_d[0])));
      bad_d = !(on && (pat_d == mas_pkg::LED_BOTH ||
                       pat_d == mas_pkg::LED_BAD ||
                       (pat_d == mas_pkg::LED_ALT && !idx_d[0])));
      int_d = !((thf_d && ctrl_d[mas_pkg::CT_OVER_HIGH_IRQ_EN]) ||
                (tlf_d && ctrl_d[mas_pkg::CT_UNDER_LOW_IRQ_EN]) ||
                (tod_alarm_flag_d && ctrl_d[mas_pkg::CT_AIE]));  // RL4 RL22
   end

   // Sync chain resets high: an idle button reads released
   always_ff @(posedge clk) begin
      if (reset) begin
         {btn_s1_q, btn_s2_q, btn_s3_q, btn_lvl_q} <= 4'hf;
         hold_q <= '0;
         cnt_q <= '0;
         run_q <= 1'b0;
         idx_q <= 2'd0;
         pat_q <= mas_pkg::LED_BOTH;
         {good_q, bad_q, int_q} <= 3'h7;
      end else begin
         btn_s1_q <= pushbutton_n;
         btn_s2_q <= btn_s1_q;
         btn_s3_q <= btn_s2_q;
         btn_lvl_q <= btn_lvl_d;
         hold_q <= hold_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
         idx_q <= idx_d;
         pat_q <= pat_d;
         {good_q, bad_q, int_q} <= {good_d, bad_d, int_d};
      end
   end

   assign reg_rdata      = rdata_q;
   assign good_led_n     = good_q;
   assign bad_led_n      = bad_q;
   assign int_n          = int_q;
   assign mission_active = mip_q;
endmodule : mas_alarm_status

// ===== shared/mas_pkg.sv
package mas_pkg;
   // Timing base
   localparam int CLK_MHZ       = 50;
   localparam int LED_PULSE_US  = 62500;   // 62.5 ms
   localparam int LED_PERIOD_US = 500000;  // 0.5 s
   localparam int BTN_HOLD_US   = 500000;  // 0.5 s
   localparam int LED_PULSE_CYC  = LED_PULSE_US * CLK_MHZ;
   localparam int LED_PERIOD_CYC = LED_PERIOD_US * CLK_MHZ;
   localparam int BTN_HOLD_CYC   = BTN_HOLD_US * CLK_MHZ;
   localparam int TIMER_W        = 25;
   localparam int LED_PULSES     = 4;

   // Register map
   localparam logic [15:0] A_SEC      = 16'h0000;
   localparam logic [15:0] A_DAY      = 16'h0003;
   localparam logic [15:0] A_ALM_SEC  = 16'h0007;
   localparam logic [15:0] A_ALM_DAY  = 16'h000a;
   localparam logic [15:0] A_TH_LO    = 16'h000b;
   localparam logic [15:0] A_TH_HI    = 16'h000c;
   localparam logic [15:0] A_CTRL     = 16'h000e;
   localparam logic [15:0] A_STATUS   = 16'h0014;
   localparam logic [15:0] A_EV_LO    = 16'h0220;
   localparam logic [15:0] A_EV_HI    = 16'h0250;
   localparam logic [15:0] EV_BYTES   = 16'h0030;
   localparam logic [3:0]  EV_ENTRIES = 4'hc;

   // Writable-bit masks; unused bits read zero
   localparam logic [7:0] M_SEC     = 8'h7f;
   localparam logic [7:0] M_MIN     = 8'h7f;
   localparam logic [7:0] M_HRS     = 8'h7f;
   localparam logic [7:0] M_DAY     = 8'h07;
   localparam logic [7:0] M_ALM     = 8'hff;
   localparam logic [7:0] M_ALM_DAY = 8'h87;
   localparam logic [7:0] M_CTRL    = 8'hdf;

   // BCD limits
   localparam logic [7:0] BCD_59 = 8'h59;
   localparam logic [7:0] BCD_23 = 8'h23;
   localparam logic [7:0] BCD_11 = 8'h11;
   localparam logic [7:0] BCD_12 = 8'h12;
   localparam logic [7:0] BCD_7  = 8'h07;
   localparam logic [7:0] BCD_0  = 8'h00;
   localparam logic [7:0] BCD_1  = 8'h01;

   // Field positions
   localparam int ST_MIP   = 5;
   localparam int ST_TLF   = 2;
   localparam int ST_THF   = 1;
   localparam int ST_TOD_ALARM_FLAG  = 0;
   localparam int CT_UNDER_LOW_IRQ_EN  = 2;
   localparam int CT_OVER_HIGH_IRQ_EN  = 1;
   localparam int CT_AIE   = 0;
   localparam int HR_12    = 6;
   localparam int HR_PM    = 5;
   localparam int ALM_MASK = 7;

   localparam logic [7:0] DUR_MAX = 8'hff;

   typedef logic [7:0] mas_byte_t;

   typedef enum logic [1:0] {
      LED_BOTH = 2'b00,
      LED_GOOD = 2'b01,
      LED_BAD  = 2'b10,
      LED_ALT  = 2'b11
   } mas_led_e;

   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mas_reg_req_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  temp;
      logic [23:0] count;
   } mas_sample_s;
endpackage : mas_pkg

// ===== tb/mas_alarm_status_assertions.sv
`timescale 1ns/1ps
module mas_alarm_status_assertions #(
   parameter int LED_PULSE_CYC = 4
) (
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  tick_1s,
   input wire mas_pkg::mas_reg_req_s reg_req,
   input wire mas_pkg::mas_sample_s  sample,
   input wire logic                  mission_start,
   input wire logic                  spec_test_cmd,
   input wire logic                  good_led_n,
   input wire logic                  bad_led_n,
   input wire logic                  int_n,
   input wire logic                  mission_active
);
   logic [7:0] lo_q, lo_d, hi_q, hi_d, ctl_q, ctl_d, cnt_q, cnt_d;
   logic [3:0] msk_q, msk_d;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Shadow of host writes, so expectations follow the live thresholds
   always_comb begin
      lo_d = lo_q;
      hi_d = hi_q;
      ctl_d = ctl_q;
      msk_d = msk_q;
      cnt_d = good_led_n ? 8'h00 : cnt_q + 8'h01;
      if (reg_req.wr) begin
         if (reg_req.addr == mas_pkg::A_TH_LO) lo_d = reg_req.wdata;
         if (reg_req.addr == mas_pkg::A_TH_HI) hi_d = reg_req.wdata;
         if (reg_req.addr == mas_pkg::A_CTRL) ctl_d = reg_req.wdata & 8'hdf;
         if (reg_req.addr >= 16'h0007 && reg_req.addr <= 16'h000a)
            msk_d[reg_req.addr[1:0] + 2'h1] = reg_req.wdata[7];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         {lo_q, hi_q, ctl_q, cnt_q, msk_q} <= '0;
      end else begin
         {lo_q, hi_q, ctl_q, cnt_q, msk_q} <= {lo_d, hi_d, ctl_d, cnt_d, msk_d};
      end
   end

   sequence s_low_smp;
      sample.valid && mission_active && sample.temp <= lo_q;
   endsequence
   sequence s_high_smp;
      sample.valid && mission_active && sample.temp >= hi_q;
   endsequence

   AST_RESET_IDLE: assert property ($fell(reset) |-> good_led_n && bad_led_n
      && int_n && !mission_active) else $error("outputs not idle");
   AST_START_BOTH: assert property (mission_start |=> !good_led_n
      && !bad_led_n) else $error("start not both leds");
   AST_START_MIP: assert property (mission_start |=> mission_active)
      else $error("mission not active");
   AST_SPEC_ONE: assert property (spec_test_cmd && !mission_start |=>
      good_led_n != bad_led_n) else $error("status not one led");
   AST_PULSE_W: assert property ($rose(good_led_n) |->
      cnt_q == 8'(LED_PULSE_CYC)) else $error("pulse width");
   AST_LOW_INT: assert property (s_low_smp and ctl_q[2] |-> ##[1:2] !int_n)
      else $error("low alarm irq");
   AST_HIGH_INT: assert property (s_high_smp and ctl_q[1] |-> ##[1:2] !int_n)
      else $error("high alarm irq");
   AST_STOP: assert property (reg_req.wr && reg_req.addr == 16'h000b &&
      reg_req.wdata != lo_q && !mission_start |=> !mission_active)
      else $error("mission not stopped");
   AST_NO_SELF: assert property (!mission_active && !mission_start |=>
      !mission_active) else $error("mission set by itself");
   AST_ALM_ALL: assert property (tick_1s && msk_q == 4'hf && ctl_q[0] |->
      ##[1:2] !int_n) else $error("alarm each second");
endmodule : mas_alarm_status_assertions

// ===== tb/mas_led_host.sv
`timescale 1ns/1ps
module mas_led_host (
   input  wire logic clk,
   input  wire logic clr,
   input  wire logic led_n,
   output logic [7:0] falls,
   output logic [7:0] width,
   output logic [7:0] gap
);
   logic [7:0] lo_n;
   logic [7:0] since;
   logic       prev = 1'b1;

   // Eye on one LED: counts flashes, last lit time, flash to flash spacing
   always @(posedge clk) begin
      prev <= led_n;
      since <= since + 8'h01;
      lo_n <= led_n ? 8'h00 : lo_n + 8'h01;
      if (clr) begin
         {falls, width, gap, since, lo_n} <= '0;
      end else if (prev && !led_n) begin
         falls <= falls + 8'h01;
         gap <= since;
         since <= 8'h01;
      end else if (!prev && led_n) begin
         width <= lo_n;
      end
   end
endmodule : mas_led_host

// ===== tb/mas_alarm_status_tb.sv
`timescale 1ns/1ps
module mas_alarm_status_tb;
   localparam int PW = 4;
   localparam int PP = 16;
   localparam int BH = 8;
   logic clk = 1'b0, reset = 1'b1, tick_1s = 1'b0, clr = 1'b0;
   logic mission_start = 1'b0, spec_test_cmd = 1'b0, pushbutton_n = 1'b1;
   mas_pkg::mas_reg_req_s reg_req = '0;
   mas_pkg::mas_sample_s  sample = '0;
   logic [7:0] reg_rdata, gf, gw, gg, bf, bw, bg;
   logic       good_led_n, bad_led_n, int_n, mission_active;
   int         err_count = 0;
   int         check_count = 0;

   always #10 clk = ~clk;

   // Short LED and button counts keep the run brief
   mas_alarm_status #(.LED_PULSE_CYC(PW), .LED_PERIOD_CYC(PP),
      .BTN_HOLD_CYC(BH)) i_dut (.clk(clk), .reset(reset), .tick_1s(tick_1s),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .sample(sample),
      .mission_start(mission_start), .spec_test_cmd(spec_test_cmd),
      .pushbutton_n(pushbutton_n), .good_led_n(good_led_n),
      .bad_led_n(bad_led_n), .int_n(int_n), .mission_active(mission_active));
   mas_led_host i_good (.clk(clk), .clr(clr), .led_n(good_led_n),
      .falls(gf), .width(gw), .gap(gg));
   mas_led_host i_bad (.clk(clk), .clr(clr), .led_n(bad_led_n),
      .falls(bf), .width(bw), .gap(bg));

   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : cyc
   task automatic summarize;
      if (err_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic pls(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pls
   // A quiet edge after each write keeps back-to-back calls clean
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_req = '{wr: 1'b1, addr: a, wdata: d};
      cyc(1);
      reg_req.wr = 1'b0;
      cyc(1);
   endtask : wr
   // Read data comes from a flop, so compare one edge after the address
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      reg_req.addr = a;
      cyc(1);
      chk(reg_rdata === e, "register read");
   endtask : rd
   task automatic rd4(input logic [15:0] a, input logic [31:0] e);
      for (int i = 0; i < 4; i++) rd(a + 16'(i), e[8*i +: 8]);
   endtask : rd4
   task automatic smp(input logic [7:0] t, input logic [23:0] c);
      sample = '{valid: 1'b1, temp: t, count: c};
      cyc(1);
      sample.valid = 1'b0;
      cyc(1);
   endtask : smp
   task automatic wait_int(input logic lvl);
      for (int n = 0; n < 4 && int_n !== lvl; n++) cyc(1);
      if (int_n !== lvl) begin
         chk(1'b0, "interrupt level timeout");
         summarize();
      end
   endtask : wait_int

   task automatic t_regs;
      rd(16'h0014, 8'h00);
      wr(16'h000b, 8'h40);
      wr(16'h000c, 8'h60);
      rd(16'h000b, 8'h40);
      rd(16'h000c, 8'h60);
      wr(16'h0000, 8'hd9);
      rd(16'h0000, 8'h59);
      wr(16'h0002, 8'h72);
      rd(16'h0002, 8'h72);
      wr(16'h000d, 8'h55);
      rd(16'h000d, 8'h00);
      wr(16'h000e, 8'h06);
   endtask : t_regs
   task automatic t_start;
      pls(clr);
      pls(mission_start);
      chk(good_led_n === 1'b0 && bad_led_n === 1'b0, "start leds");
      cyc(70);
      chk(gf === 8'h04 && bf === 8'h04, "start flashes");
      chk(gw === 8'(PW) && bw === 8'(PW) && gg === 8'(PP), "timing");
   endtask : t_start
   // Restart lands in a dark gap of the start pattern
   task automatic t_alt;
      pls(mission_start);
      cyc(8);
      pls(spec_test_cmd);
      cyc(1);
      chk(bad_led_n === 1'b0 && good_led_n === 1'b1, "alt 1st");
      cyc(PP);
      chk(good_led_n === 1'b0 && bad_led_n === 1'b1, "alt 2nd");
      cyc(60);
   endtask : t_alt
   task automatic t_exc;
      smp(8'h50, 24'h000001);
      rd(16'h0014, 8'h20);
      smp(8'h40, 24'h000010);
      rd(16'h0014, 8'h24);
      wait_int(1'b0);
      rd4(16'h0220, 32'h01000010);
      smp(8'h3f, 24'h000011);
      smp(8'h50, 24'h000012);
      rd(16'h0014, 8'h24);
      smp(8'h40, 24'h000020);
      rd4(16'h0220, 32'h02000010);
      rd4(16'h0224, 32'h01000020);
      smp(8'h60, 24'h000030);
      rd4(16'h0250, 32'h01000030);
      rd(16'h0014, 8'h26);
      wr(16'h0014, 8'h20);
      rd(16'h0014, 8'h20);
      wait_int(1'b1);
   endtask : t_exc
   task automatic t_long;
      smp(8'h50, 24'h000040);
      for (int i = 0; i < 256; i++) smp(8'h40, 24'h000100 + 24'(i));
      rd4(16'h0228, 32'hff000100);
      rd4(16'h022c, 32'h010001ff);
      for (int e = 0; e < 9; e++) begin
         smp(8'h50, 24'h000000);
         smp(8'h40, 24'h000500 + 24'(e));
      end
      rd4(16'h024c, 32'h01000507);
      rd4(16'h0250, 32'h01000030);
      rd(16'h0280, 8'h00);
   endtask : t_long
   task automatic t_spec(input logic bad);
      pls(clr);
      pls(spec_test_cmd);
      cyc(1);
      chk(bad_led_n === !bad && good_led_n === bad, "status led");
      cyc(70);
      chk(bf === (bad ? 8'h04 : 8'h00) && gf === (bad ? 8'h00 : 8'h04),
         "status flashes");
   endtask : t_spec
   // Held button asks for status once the mission runs
   task automatic t_btn;
      pls(clr);
      pushbutton_n = 1'b0;
      cyc(BH + 8);
      pushbutton_n = 1'b1;
      cyc(70);
      chk(gf === 8'h04 && bf === 8'h00, "button status");
   endtask : t_btn
   task automatic t_stop;
      wr(16'h000b, 8'h40);
      chk(mission_active === 1'b1, "same value kept mission");
      wr(16'h000b, 8'h41);
      chk(mission_active === 1'b0, "mission not stopped");
   endtask : t_stop
   task automatic t_alm;
      wr(16'h000e, 8'h01);
      wr(16'h0014, 8'h00);
      for (int i = 0; i < 4; i++) wr(16'h0007 + 16'(i), 8'h80);
      pls(tick_1s);
      rd(16'h0014, 8'h01);
      wait_int(1'b0);
      wr(16'h0014, 8'h00);
      wr(16'h000e, 8'h00);
      pls(tick_1s);
      rd(16'h0014, 8'h01);
      cyc(2);
      chk(int_n === 1'b1, "alarm irq masked");
      wr(16'h0014, 8'h00);
      wr(16'h0000, 8'h10);
      wr(16'h0007, 8'h11);
      pls(tick_1s);
      rd(16'h0014, 8'h01);
      wr(16'h0014, 8'h00);
      wr(16'h0007, 8'h13);
      pls(tick_1s);
      rd(16'h0014, 8'h00);
   endtask : t_alm

   initial begin
      cyc(5);
      reset = 1'b0;
      t_regs();
      t_start();
      t_alt();
      t_exc();
      t_long();
      t_spec(1'b1);
      pls(mission_start);
      cyc(70);
      smp(8'h50, 24'h000001);
      t_spec(1'b0);
      t_btn();
      t_stop();
      t_alm();
      summarize();
   end
endmodule : mas_alarm_status_tb

bind mas_alarm_status mas_alarm_status_assertions #(
   .LED_PULSE_CYC(LED_PULSE_CYC)) i_chk (.clk(clk), .reset(reset),
   .tick_1s(tick_1s), .reg_req(reg_req), .sample(sample),
   .mission_start(mission_start), .spec_test_cmd(spec_test_cmd),
   .good_led_n(good_led_n), .bad_led_n(bad_led_n), .int_n(int_n),
   .mission_active(mission_active));
